// ===== adc_seq_pkg.sv
/*
 Shared constants and types for the converter sequencer.
 Assumes a single 25 MHz clock and that configuration is held steady while the converter is on.
*/
`default_nettype none
package adc_seq_pkg;
	localparam int RESULT_WIDTH = 10;
	localparam int BUF_DEPTH = 16;
	localparam int HALF_DEPTH = 8;
	localparam int INPUT_COUNT = 16;
	localparam int CLOCK_MHZ = 25;
	localparam int CLOCK_PERIOD_NS = 40;
	// Field positions inside the second control register
	localparam int SPI_LSB = 2;
	localparam int SPI_MSB = 5;
	localparam int SCAN_EN_BIT = 10;
	// Trigger source codes
	localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
	localparam logic [2:0] TRIG_EXTERNAL = 3'h1;
	localparam logic [2:0] TRIG_TIMER = 3'h2;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	// Channel count codes; 2 and 3 both mean four channels
	localparam logic [1:0] CHAN_ONE = 2'h0;
	localparam logic [1:0] CHAN_TWO = 2'h1;
	// Read formats
	localparam logic [1:0] FORM_INTEGER = 2'h0;
	localparam logic [1:0] FORM_SIGNED_INT = 2'h1;
	localparam logic [1:0] FORM_FRACTION = 2'h2;
	localparam logic [1:0] FORM_SIGNED_FRAC = 2'h3;
	// Reset values, SAR start point, auto-sample minimum and conversion clock step
	localparam logic [3:0] RESET_NIBBLE = 4'h0;
	localparam logic [3:0] SAR_MSB_INDEX = 4'h9;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
	localparam logic [4:0] AUTO_SAMPLE_MIN = 5'h01;
	localparam logic [6:0] TAD_STEP = 7'h02;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SAMPLE = 2'b01,
		S_CONVERT = 2'b10
	} seq_state_e;

	typedef struct packed {
		logic converter_on;
		logic [2:0] trigger_source_select;
		logic auto_sample_enable;
		logic simultaneous_sample;
		logic buffer_split_mode;
		logic alternate_input_select;
		logic [1:0] channel_count_select;
		logic reference_external;
		logic [1:0] result_format;
		logic [4:0] auto_sample_time;
		logic [5:0] conversion_clock_divider;
		logic [3:0] input_set_a;
		logic [3:0] input_set_b;
	} seq_config_s;
endpackage
`default_nettype wire

// ===== adc_sample_convert_sequencer.sv
/*
 Sequencing and control logic of a 10-bit successive-approximation converter:
 sampling, triggers, channel grouping, input alternation and scanning, result buffer.
 Assumes the analog front end returns the SAR comparator decision on comparator_i
 within one conversion clock, and that all inputs are synchronous to clk_i.
*/
// Notes on behaviour
// - Sixteen 10-bit result words, read as formatted 16-bit words, never written by software.
// - Sample request starts acquisition; the selected trigger ends it and starts conversion.
// - Each conversion is stored; flag and done rise after the programmed sequence count.
// - Sequential mode samples and converts each channel in turn, one sample per channel.
// - Simultaneous mode samples all channels together, converts one after another.
// - Channel count picks one, two or four sample-and-hold channels from zero upward.
// - Samples-per-interrupt sets one to sixteen sequences between interrupts.
// - Split mode fills one 8-word half, then the other, switching at each interrupt.
// - Samples-per-interrupt lives at bits 5:2; value 0111 fills exactly one half with one channel.
// - Alternate off uses set A; on alternates set A and set B each sequence.
// - Scan enable (bit 10) steps channel zero's set A input through selected inputs.
// - Scan goes low to high, restarts at each interrupt, unused higher inputs skipped.
// - Sixteen inputs feed four sample-and-hold channels and a 10-bit SAR.
// - Software selects the analog supply pair or external pins as reference.
// - The converter keeps working while the rest of the device sleeps.
// - Software trigger fires on clearing sample request; auto trigger after programmed clocks.
// - Turning converter off aborts conversion, keeps buffer, and beats a coincident start.
// - Conversion clock period is instruction period times half of divider plus one.
`default_nettype none
module adc_sample_convert_sequencer
	import adc_seq_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire seq_config_s config_i,
	input wire logic [15:0] second_control_register_i,
	input wire logic [15:0] scan_select_register_i,
	input wire logic sample_request_set_i,
	input wire logic sample_request_clear_i,
	input wire logic timer_trigger_i,
	input wire logic external_trigger_i,
	input wire logic flag_clear_i,
	input wire logic comparator_i,
	input wire logic [3:0] read_addr_i,
	output logic sample_request_o,
	output logic [3:0] sample_hold_o,
	output logic [3:0] ch0_input_o,
	output logic input_set_b_o,
	output logic [1:0] active_channel_o,
	output logic [9:0] dac_code_o,
	output logic converting_o,
	output logic conversion_interrupt_flag_o,
	output logic done_o,
	output logic buffer_half_o,
	output logic reference_external_o,
	output logic [15:0] read_data_o
);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] channel_mask(input logic [1:0] sel);
		if (sel == CHAN_ONE) begin
			return 4'h1;
		end else if (sel == CHAN_TWO) begin
			return 4'h3;
		end
		return 4'hF;
	endfunction

	// Lowest selected input at or above start, wrapping to the lowest selected one
	function automatic logic [3:0] scan_pick(input logic [15:0] mask, input logic [4:0] start);
		logic [3:0] above;
		logic [3:0] lowest;
		logic found;
		above = RESET_NIBBLE;
		lowest = RESET_NIBBLE;
		found = 1'b0;
		for (int i = INPUT_COUNT - 1; i >= 0; i--) begin
			if (mask[i]) begin
				lowest = 4'(i);
				if (5'(i) >= start) begin
					above = 4'(i);
					found = 1'b1;
				end
			end
		end
		return found ? above : lowest;
	endfunction

	function automatic logic [15:0] format_word(input logic [9:0] d, input logic [1:0] form);
		case (form)
			FORM_SIGNED_INT: return {{6{~d[9]}}, ~d[9], d[8:0]};
			FORM_FRACTION: return {d, 6'h00};
			FORM_SIGNED_FRAC: return {~d[9], d[8:0], 6'h00};
			default: return {6'h00, d};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	seq_state_e state;
	logic [6:0] tad_acc;
	logic tad_tick;
	logic [4:0] sample_request_cnt;
	logic [3:0] bit_idx;
	logic [9:0] sar_result;
	logic [1:0] chan_idx;
	logic [3:0] seq_count;
	logic [3:0] wr_ptr;
	logic [3:0] scan_pos;
	logic set_b_phase;
	logic [9:0] result_mem [BUF_DEPTH];

	logic on;
	logic [3:0] spi;
	logic scan_en;
	logic [3:0] used_mask;
	logic trigger;
	logic conv_done;
	logic last_chan;
	logic seq_end;
	logic irq_event;
	logic [9:0] final_result;
	logic [3:0] wr_addr;
	logic [4:0] auto_sample_time_min;
	logic [6:0] next_tad;
	logic [3:0] next_hold;
	logic [1:0] next_chan;

	assign on = config_i.converter_on;
	assign spi = second_control_register_i[SPI_MSB:SPI_LSB];
	assign scan_en = second_control_register_i[SCAN_EN_BIT];
	assign used_mask = channel_mask(config_i.channel_count_select);
	assign auto_sample_time_min = (config_i.auto_sample_time == 5'h00) ? AUTO_SAMPLE_MIN
		: config_i.auto_sample_time;
	assign next_tad = tad_acc + TAD_STEP;
	assign conv_done = on && state == S_CONVERT && tad_tick && bit_idx == 4'h0;
	// Last channel is the top of the mask; a sum on the mask would wrap at four channels
	assign last_chan = (chan_idx == 2'h3) || !used_mask[chan_idx + 2'h1];
	assign next_chan = (!on || (conv_done && last_chan)) ? 2'h0
		: conv_done ? chan_idx + 2'h1 : chan_idx;
	assign seq_end = conv_done && last_chan;
	assign irq_event = seq_end && seq_count == spi;
	assign final_result = sar_result | {9'h000, comparator_i};
	assign wr_addr = config_i.buffer_split_mode ? {buffer_half_o, wr_ptr[2:0]} : wr_ptr;

	always_comb begin
		case (config_i.trigger_source_select)
			TRIG_SOFTWARE: trigger = sample_request_clear_i;
			TRIG_EXTERNAL: trigger = external_trigger_i;
			TRIG_TIMER: trigger = timer_trigger_i;
			TRIG_AUTO: trigger = tad_tick && (sample_request_cnt + 5'h01 >= auto_sample_time_min);
			default: trigger = 1'b0;
		endcase
	end

	always_comb begin
		next_hold = 4'h0;
		if (on && state == S_SAMPLE) begin
			if (config_i.simultaneous_sample) begin
				next_hold = used_mask;
			end else begin
				next_hold = 4'h1 << chan_idx;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion clock: adds two per instruction clock against divider plus one,
	// so even dividers average half-cycle periods without a second clock domain.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tad_acc <= 7'h00;
			tad_tick <= 1'b0;
		end else if (enable_i) begin
			if (state == S_IDLE) begin
				tad_acc <= 7'h00;
				tad_tick <= 1'b0;
			end else if (next_tad >= {1'b0, config_i.conversion_clock_divider} + 7'h01) begin
				tad_acc <= next_tad - ({1'b0, config_i.conversion_clock_divider} + 7'h01);
				tad_tick <= 1'b1;
			end else begin
				tad_acc <= next_tad;
				tad_tick <= 1'b0;
			end
		end
	end

	// Sequencer; converter off is tested first so an abort beats any start
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state <= S_IDLE;
			sample_request_o <= 1'b0;
			sample_request_cnt <= 5'h00;
			chan_idx <= 2'h0;
		end else if (enable_i) begin
			if (!on) begin
				state <= S_IDLE;
				sample_request_o <= 1'b0;
				sample_request_cnt <= 5'h00;
				chan_idx <= 2'h0;
			end else begin
				case (state)
					S_IDLE: begin
						if (sample_request_set_i) begin
							sample_request_o <= 1'b1;
						end
						if (sample_request_o) begin
							state <= S_SAMPLE;
						end
						sample_request_cnt <= 5'h00;
					end
					S_SAMPLE: begin
						if (trigger) begin
							state <= S_CONVERT;
							sample_request_o <= 1'b0;
							sample_request_cnt <= 5'h00;
						end else if (tad_tick) begin
							sample_request_cnt <= sample_request_cnt + 5'h01;
						end
					end
					S_CONVERT: begin
						if (conv_done) begin
							if (!last_chan) begin
								chan_idx <= chan_idx + 2'h1;
								if (!config_i.simultaneous_sample) begin
									state <= S_SAMPLE;
									sample_request_o <= 1'b1;
								end
							end else begin
								chan_idx <= 2'h0;
								state <= config_i.auto_sample_enable ? S_SAMPLE : S_IDLE;
								sample_request_o <= config_i.auto_sample_enable;
							end
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// Successive approximation, one bit per conversion clock from the MSB down
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			bit_idx <= SAR_MSB_INDEX;
			sar_result <= 10'h000;
			dac_code_o <= 10'h000;
		end else if (enable_i) begin
			if (state != S_CONVERT || !on || conv_done) begin
				bit_idx <= SAR_MSB_INDEX;
				sar_result <= 10'h000;
				dac_code_o <= SAR_FIRST_TRIAL;
			end else if (tad_tick) begin
				sar_result <= sar_result | (10'(comparator_i) << bit_idx);
				dac_code_o <= sar_result | (10'(comparator_i) << bit_idx)
					| (SAR_FIRST_TRIAL >> (SAR_MSB_INDEX - bit_idx + 4'h1));
				bit_idx <= bit_idx - 4'h1;
			end
		end
	end

	// Result buffer has no software write path and keeps its words across reset
	always_ff @(posedge clk_i) begin
		if (enable_i && conv_done) begin
			result_mem[wr_addr] <= final_result;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			read_data_o <= 16'h0000;
		end else if (enable_i) begin
			read_data_o <= format_word(result_mem[read_addr_i], config_i.result_format);
		end
	end

	// Write pointer, sequence count and buffer half
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wr_ptr <= RESET_NIBBLE;
			seq_count <= RESET_NIBBLE;
			buffer_half_o <= 1'b0;
		end else if (enable_i) begin
			if (!on) begin
				wr_ptr <= RESET_NIBBLE;
				seq_count <= RESET_NIBBLE;
				buffer_half_o <= 1'b0;
			end else if (irq_event) begin
				wr_ptr <= RESET_NIBBLE;
				seq_count <= RESET_NIBBLE;
				if (config_i.buffer_split_mode) begin
					buffer_half_o <= ~buffer_half_o;
				end
			end else if (conv_done) begin
				wr_ptr <= wr_ptr + 4'h1;
				if (seq_end) begin
					seq_count <= seq_count + 4'h1;
				end
			end
		end
	end

	// Input set alternation and channel zero scan position
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			set_b_phase <= 1'b0;
			scan_pos <= RESET_NIBBLE;
		end else if (enable_i) begin
			if (!on || irq_event) begin
				scan_pos <= scan_pick(scan_select_register_i, 5'h00);
			end else if (conv_done && chan_idx == 2'h0 && !set_b_phase) begin
				scan_pos <= scan_pick(scan_select_register_i, {1'b0, scan_pos} + 5'h01);
			end
			if (!on || !config_i.alternate_input_select) begin
				set_b_phase <= 1'b0;
			end else if (seq_end) begin
				set_b_phase <= ~set_b_phase;
			end
		end
	end

	// Flag and done: a new event wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			conversion_interrupt_flag_o <= 1'b0;
			done_o <= 1'b0;
		end else if (enable_i) begin
			if (irq_event) begin
				conversion_interrupt_flag_o <= 1'b1;
				done_o <= 1'b1;
			end else begin
				if (flag_clear_i) begin
					conversion_interrupt_flag_o <= 1'b0;
				end
				if (sample_request_set_i) begin
					done_o <= 1'b0;
				end
			end
		end
	end

	// Registered analog controls; runs on clk_i alone so it continues in sleep
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sample_hold_o <= 4'h0;
			ch0_input_o <= RESET_NIBBLE;
			input_set_b_o <= 1'b0;
			active_channel_o <= 2'h0;
			converting_o <= 1'b0;
			reference_external_o <= 1'b0;
		end else if (enable_i) begin
			sample_hold_o <= next_hold;
			input_set_b_o <= set_b_phase;
			if (set_b_phase) begin
				ch0_input_o <= config_i.input_set_b;
			end else if (scan_en) begin
				ch0_input_o <= scan_pos;
			end else begin
				ch0_input_o <= config_i.input_set_a;
			end
			// Follows the next channel so back-to-back conversions compare the right hold
			active_channel_o <= next_chan;
			converting_o <= on && state == S_CONVERT;
			reference_external_o <= config_i.reference_external;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_abort_to_idle: assert property (enable_i && !on |=> state == S_IDLE)
		else $error("converter off did not return sequencer to idle");
	a_abort_no_write: assert property (enable_i && !on
		|=> !converting_o && sample_hold_o == 4'h0 && !conv_done)
		else $error("conversion continued while converter off");
	a_sample_start: assert property (enable_i && on && state == S_IDLE && sample_request_o
		|=> state == S_SAMPLE)
		else $error("sample request did not start acquisition");
	a_soft_trigger: assert property (enable_i && on && state == S_SAMPLE
		&& config_i.trigger_source_select == TRIG_SOFTWARE && sample_request_clear_i
		|=> state == S_CONVERT && !sample_request_o)
		else $error("software trigger did not start conversion");
	a_flag_after_count: assert property ($rose(conversion_interrupt_flag_o)
		|-> $past(seq_end) && $past(seq_count) == $past(spi))
		else $error("flag raised before programmed sequence count");
	a_split_toggle: assert property (enable_i && irq_event && config_i.buffer_split_mode
		|=> buffer_half_o != $past(buffer_half_o))
		else $error("buffer half did not switch at interrupt");
	a_split_range: assert property (conv_done && config_i.buffer_split_mode
		|-> wr_addr[3] == buffer_half_o)
		else $error("split write outside active half");
	a_seq_track: assert property (on && state == S_SAMPLE && !config_i.simultaneous_sample
		|-> $onehot(next_hold) && (next_hold & ~used_mask) == 4'h0)
		else $error("sequential sampling tracks wrong channels");
	a_simul_track: assert property (enable_i && on && state == S_SAMPLE
		&& config_i.simultaneous_sample
		|=> sample_hold_o == $past(used_mask))
		else $error("simultaneous sampling misses a channel");
	a_scan_select: assert property (enable_i && on && $past(on) && scan_en && !set_b_phase
		&& scan_select_register_i != 16'h0000
		|=> scan_select_register_i[ch0_input_o])
		else $error("scan selected an unlisted input");

	c_interrupt: cover property (irq_event);
	c_split_swap: cover property (irq_event && config_i.buffer_split_mode);
	c_simul_four: cover property (seq_end && config_i.simultaneous_sample && chan_idx == 2'h3);
	c_abort: cover property (state == S_CONVERT && !on);

endmodule
`default_nettype wire

// ===== adc_front_model.sv
/*
 Analog front end model: four sample-and-hold channels and the SAR comparator.
 Assumes a hold switch is high while its channel tracks and the trial code is combinational.
*/
`default_nettype none
module adc_front_model (
	input wire logic clk_i,
	input wire logic [3:0][9:0] level_i,
	input wire logic [3:0] sample_hold_i,
	input wire logic [1:0] active_channel_i,
	input wire logic [9:0] dac_code_i,
	output logic comparator_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0][9:0] held;
	//////////////////////////////////////////////////////////////////////////////
	// Value freezes when the switch opens, so late input changes are not seen
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (sample_hold_i[i]) begin
				held[i] <= level_i[i];
			end
		end
	end
	assign comparator_o = (dac_code_i <= held[active_channel_i]);
endmodule
`default_nettype wire

// ===== adc_sample_convert_sequencer_tb_top.sv
/*
 Self-checking bench for the converter sequencer with the front end model.
 Assumes 25 MHz clock; configuration is changed only while the converter is off.
*/
`default_nettype none
module adc_sample_convert_sequencer_tb_top import adc_seq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [9:0] lvl;
		logic [1:0] form;
		logic [2:0] src;
		logic [15:0] exp;
	} row_s;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	seq_config_s cfg = '0;
	seq_config_s base;
	logic [15:0] ctl2 = 16'h0000;
	logic [15:0] scan_sel = 16'h0000;
	logic set_p = 1'b0, clr_p = 1'b0, tmr_p = 1'b0, ext_p = 1'b0, fclr_p = 1'b0;
	logic [3:0] raddr = 4'h0;
	logic en = 1'b1;
	logic [3:0][9:0] lev = '0;
	logic sreq, cmp, set_b, conv, flag, done, half, ref_ext;
	logic [3:0] hold, ch0_in;
	logic [1:0] act;
	logic [9:0] dac;
	logic [15:0] rdata;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	row_s rows [6] = '{'{10'h3FF, FORM_INTEGER, TRIG_SOFTWARE, 16'h03FF},
		'{10'h155, FORM_FRACTION, TRIG_EXTERNAL, 16'h5540},
		'{10'h155, FORM_SIGNED_INT, TRIG_SOFTWARE, 16'hFF55},
		'{10'h2AA, FORM_SIGNED_FRAC, TRIG_SOFTWARE, 16'h2A80},
		'{10'h000, FORM_INTEGER, TRIG_TIMER, 16'h0000},
		'{10'h2AA, FORM_FRACTION, TRIG_AUTO, 16'hAA80}};

	always #20 clk_i = ~clk_i;

	adc_sample_convert_sequencer u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(en),
		.config_i(cfg), .second_control_register_i(ctl2), .scan_select_register_i(scan_sel),
		.sample_request_set_i(set_p), .sample_request_clear_i(clr_p), .timer_trigger_i(tmr_p),
		.external_trigger_i(ext_p), .flag_clear_i(fclr_p), .comparator_i(cmp),
		.read_addr_i(raddr), .sample_request_o(sreq), .sample_hold_o(hold),
		.ch0_input_o(ch0_in), .input_set_b_o(set_b), .active_channel_o(act), .dac_code_o(dac),
		.converting_o(conv), .conversion_interrupt_flag_o(flag), .done_o(done),
		.buffer_half_o(half), .reference_external_o(ref_ext), .read_data_o(rdata));

	adc_front_model u_front (.clk_i(clk_i), .level_i(lev), .sample_hold_i(hold),
		.active_channel_i(act), .dac_code_i(dac), .comparator_o(cmp));

	//////////////////////////////////////////////////////////////////////////////
	task tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("CHECK FAILED %0t run too long", $time);
			tally_and_finish();
		end
	end

	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task chk_flag(input logic got, input logic exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t %s got %b exp %b", $time, msg, got, exp);
		end
	endtask

	// Mask order is {flag clear, timer, external, request clear, request set}
	task pulse(input logic [4:0] m);
		{fclr_p, tmr_p, ext_p, clr_p, set_p} = m;
		step(1);
		{fclr_p, tmr_p, ext_p, clr_p, set_p} = 5'h00;
		step(1);
	endtask

	function automatic logic probe(input int w);
		case (w)
			0: return conv;
			1: return flag;
			default: return |hold;
		endcase
	endfunction

	task wt(input int w, input logic v);
		for (int i = 0; i < 400 && probe(w) !== v; i++) step(1);
		chk_flag(probe(w), v, "wait");
	endtask

	task one_conv(input logic [2:0] src);
		pulse(5'h01);
		wt(2, 1'b1);
		step(2);
		case (src)
			TRIG_EXTERNAL: pulse(5'h04);
			TRIG_TIMER: pulse(5'h08);
			TRIG_SOFTWARE: pulse(5'h02);
			default: ;
		endcase
		wt(0, 1'b1);
		wt(0, 1'b0);
		step(2);
	endtask

	task rd(input logic [3:0] a, input logic [15:0] exp, input string msg);
		raddr = a;
		step(2);
		chk_word(rdata, exp, msg);
	endtask

	// Settings change only while the converter is off
	task reconf(input seq_config_s c, input logic [15:0] c2, input logic [15:0] ss);
		cfg.converter_on = 1'b0;
		step(1);
		c.converter_on = 1'b0;
		cfg = c;
		ctl2 = c2;
		scan_sel = ss;
		step(1);
		cfg.converter_on = 1'b1;
		step(2);
		pulse(5'h10);
	endtask

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		seq_config_s c;
		logic [9:0] d0;
		base = '0;
		base.converter_on = 1'b1;
		base.auto_sample_time = 5'h02;
		base.input_set_a = 4'h3;
		base.input_set_b = 4'h9;
		step(4);
		reset_n_i = 1'b1;
		for (int r = 0; r < 6; r++) begin
			c = base;
			c.result_format = rows[r].form;
			c.trigger_source_select = rows[r].src;
			reconf(c, 16'h0000, 16'h0000);
			lev[0] = rows[r].lvl;
			one_conv(rows[r].src);
			chk_flag(flag, 1'b1, "flag");
			chk_flag(done, 1'b1, "done");
			rd(4'h0, rows[r].exp, "row word");
		end
		$display("test rows done");
		// Reset clears the sequencer but leaves the buffer alone
		reset_n_i = 1'b0;
		step(2);
		chk_word({sreq, hold, ch0_in, set_b, act, conv, flag, done, half}, 16'h0000, "reset");
		reset_n_i = 1'b1;
		rd(4'h0, 16'hAA80, "kept word");
		$display("test reset done");
		reconf(base, 16'h001C, 16'h0000);
		c = base;
		c.buffer_split_mode = 1'b1;
		reconf(c, 16'h001C, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			lev[0] = 10'h100 + 10'(i);
			one_conv(TRIG_SOFTWARE);
			chk_flag(flag, i == 7, "count flag");
		end
		chk_flag(half, 1'b1, "half");
		lev[0] = 10'h1F0;
		one_conv(TRIG_SOFTWARE);
		rd(4'h7, 16'h0107, "half end");
		rd(4'h8, 16'h01F0, "upper half");
		rd(4'h0, 16'h0100, "lower kept");
		$display("test split done");
		// Neighbouring channels differ in the top bit to expose a stale channel select
		lev = {10'h240, 10'h030, 10'h220, 10'h010};
		for (int s = 0; s < 2; s++) begin
			c = base;
			c.channel_count_select = 2'h2;
			c.simultaneous_sample = s[0];
			c.trigger_source_select = TRIG_AUTO;
			reconf(c, 16'h0000, 16'h0000);
			pulse(5'h01);
			wt(2, 1'b1);
			chk_word({12'h000, hold}, s ? 16'h000F : 16'h0001, "hold mask");
			wt(1, 1'b1);
			for (int k = 0; k < 4; k++) rd(4'(k), {6'h00, lev[k]}, "channel");
		end
		$display("test channels done");
		reconf(base, 16'h0404, 16'h0024);
		chk_word({12'h000, ch0_in}, 16'h0002, "scan first");
		one_conv(TRIG_SOFTWARE);
		chk_word({12'h000, ch0_in}, 16'h0005, "scan next");
		chk_flag(flag, 1'b0, "early flag");
		one_conv(TRIG_SOFTWARE);
		chk_word({12'h000, ch0_in}, 16'h0002, "scan restart");
		$display("test scan done");
		c = base;
		c.alternate_input_select = 1'b1;
		reconf(c, 16'h0000, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			chk_flag(set_b, i[0], "set b");
			chk_word({12'h000, ch0_in}, i[0] ? 16'h0009 : 16'h0003, "set input");
			one_conv(TRIG_SOFTWARE);
		end
		$display("test alternate done");
		c = base;
		c.auto_sample_enable = 1'b1;
		c.trigger_source_select = TRIG_AUTO;
		reconf(c, 16'h0004, 16'h0000);
		pulse(5'h01);
		wt(1, 1'b1);
		chk_flag(sreq, 1'b1, "auto restart");
		rd(4'h1, 16'h0010, "auto word");
		$display("test auto done");
		reconf(base, 16'h0000, 16'h0000);
		lev[0] = 10'h0AA;
		one_conv(TRIG_SOFTWARE);
		lev[0] = 10'h0F0;
		pulse(5'h01);
		chk_flag(done, 1'b0, "done clear");
		wt(2, 1'b1);
		pulse(5'h02);
		wt(0, 1'b1);
		step(3);
		cfg.converter_on = 1'b0;
		step(2);
		chk_flag(conv, 1'b0, "abort");
		chk_flag(sreq, 1'b0, "abort request");
		rd(4'h0, 16'h00AA, "abort word");
		for (int i = 0; i < 2; i++) begin
			cfg.reference_external = i[0];
			step(2);
			chk_flag(ref_ext, i[0], "reference");
		end
		$display("test abort done");
		reconf(base, 16'h0000, 16'h0000);
		lev[0] = 10'h155;
		pulse(5'h01);
		wt(2, 1'b1);
		pulse(5'h02);
		wt(0, 1'b1);
		step(2);
		en = 1'b0;
		d0 = dac;
		step(5);
		chk_word({6'h00, dac}, {6'h00, d0}, "frozen code");
		chk_flag(conv, 1'b1, "frozen conv");
		en = 1'b1;
		wt(0, 1'b0);
		rd(4'h0, 16'h0155, "after freeze");
		$display("test enable done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
